/* File: hw/sbis_sequencer.v */
// Purpose: Holding-brake interlock sequencer: servo on/off, alarm stop and brake release timing.
// Assumes: Host commands, speed and alarm inputs come from logic on clk; main power sense is a pin.
// Notes:   Delays count whole milliseconds; speeds are unsigned magnitudes in r/min.
//          One millisecond of delay is TICK_CYCLES clocks.
//          Alarm and power-loss flags stay set until alarmReset.
//          Main power sense passes a two-stage synchroniser.
//
// How it works
// - Stopped servo-off: keep release and power until standstill delay ends.
// - Rotating servo-off: drop release at running delay or at 30 r/min.
// - Running off or alarm: hold-off ends at delay or below release speed.
// - Servo-on only entered at or below 30 r/min; reassert waits for stop.
// - Servo-on request while off, alarm-free and rotating raises warning 95 and is discarded.
// - Brake release output is servo release (servo on or hold-off) OR network request.
// - Brake release is driven onto a selectable general-purpose output.
// - Servo-off dynamic brake mode follows the servo-off stop selection.
// - Alarm dynamic brake mode follows alarm stop selection, alarm timing used.
// - Main power lost while running raises power alarm, alarm timing follows.
// - After alarm reset the servo stays off until a fresh servo-on.
`include "sbis_regs.vh"
`default_nettype none

module sbis_sequencer #(
    parameter integer TICK_CYCLES = `SBIS_TICK_CYCLES,
    parameter integer GP_WIDTH    = 4,
    parameter integer GP_SEL_W    = 2
) (
    // Clock and reset
    input  wire                clk,
    input  wire                reset,
    // Host network commands
    input  wire                servoOnCmd,
    input  wire                networkBrakeRelease,
    input  wire                alarmReset,
    // Drive status
    input  wire [15:0]         motorSpeed,
    input  wire                alarmIn,
    input  wire                mainPowerOk,
    // Configuration
    input  wire [15:0]         standstillBrakeDelay,
    input  wire [15:0]         runningBrakeDelay,
    input  wire [15:0]         brakeReleaseSpeed,
    input  wire [3:0]          servoOffStopSelect,
    input  wire [3:0]          alarmStopSelect,
    input  wire [GP_SEL_W-1:0] brakeOutputSelect,
    input  wire [GP_WIDTH-1:0] generalOutputValue,
    // Drive controls
    output reg                 motorPowerOn,
    output reg                 servoOnState,
    output reg                 brakeReleaseOutput,
    output reg  [GP_WIDTH-1:0] generalOutputs,
    output reg                 dynamicBrakeActive,
    output reg  [3:0]          dynamicBrakeMode,
    // Alarms and warnings
    output reg                 alarmActive,
    output reg                 powerLossAlarm,
    output reg  [7:0]          warningCode,
    output reg                 warningPulse
);

    // ============================================================
    // Helpers
    function atOrBelow;
        input [15:0] speed;
        input [15:0] limit;
        begin
            atOrBelow = (speed <= limit);
        end
    endfunction

    // True in either brake hold-off state.
    function isHold;
        input [1:0] st;
        begin
            isHold = (st == `SBIS_ST_STOP_HOLD) || (st == `SBIS_ST_RUN_HOLD);
        end
    endfunction

    // Tick counter wrap point, cut to the counter width on purpose.
    localparam [31:0] TICK_LAST_FULL = TICK_CYCLES - 1;
    localparam [13:0] TICK_LAST      = TICK_LAST_FULL[13:0];

    // ============================================================
    // Pin synchroniser for main power sense
    // Both stages reset high, so that leaving reset never looks like a power
    // loss. Only the second stage is read by the logic.
    reg powerMeta_reg;
    reg powerSync_reg;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            powerMeta_reg <= 1'b1;
            powerSync_reg <= 1'b1;
        end else begin
            powerMeta_reg <= mainPowerOk;
            powerSync_reg <= powerMeta_reg;
        end
    end

    // ============================================================
    // State, timer and request tracking
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [15:0] delayCnt_reg;
    reg [15:0] delayCnt_next;
    reg [13:0] tickCnt_reg;
    reg [13:0] tickCnt_next;
    reg        cmdPrev_reg;
    reg        pendingOn_reg;
    reg        pendingOn_next;
    reg        alarmMode_reg;
    reg        alarmMode_next;
    reg        alarm_next;
    reg        powerAlarm_next;
    reg        warn_next;
    reg        restart;

    // A servo-on request is the rising edge of the host level. cmdPrev resets
    // low, so a command already high when reset ends counts as a new request.
    // Power loss only raises an alarm while the motor is excited and turning.
    wire stopped      = atOrBelow(motorSpeed, `SBIS_STOP_SPEED_RPM);
    wire belowRelease = atOrBelow(motorSpeed, brakeReleaseSpeed);
    wire onEdge       = servoOnCmd & ~cmdPrev_reg;
    wire powerLost    = ~powerSync_reg & motorPowerOn & ~stopped;
    wire alarmEvent   = alarmIn | powerLost;
    wire delayDone    = (delayCnt_reg == `SBIS_DELAY_RESET);
    wire inHold       = isHold(state_reg);

    // ============================================================
    // Sequencer next state
    always @* begin
        state_next      = state_reg;
        pendingOn_next  = pendingOn_reg;
        alarmMode_next  = alarmMode_reg;
        restart         = 1'b0;
        warn_next       = 1'b0;
        // Both flags are sticky; a new event wins over a reset in the same cycle.
        // Power loss alarm
        powerAlarm_next = powerLost | (powerLossAlarm & ~alarmReset);
        alarm_next      = alarmEvent | (alarmActive & ~alarmReset);

        case (state_reg)
            `SBIS_ST_OFF: begin
                // While an alarm is latched the servo stays off until a fresh edge.
                alarmMode_next = alarm_next;
                if (alarm_next) begin
                    pendingOn_next = 1'b0;
                end else if (onEdge && !stopped) begin
                    warn_next      = 1'b1;
                    pendingOn_next = 1'b0;
                end else if ((onEdge || pendingOn_reg) && servoOnCmd && stopped) begin
                    state_next     = `SBIS_ST_ON;
                    pendingOn_next = 1'b0;
                end else if (!servoOnCmd) begin
                    pendingOn_next = 1'b0;
                end
            end
            `SBIS_ST_ON: begin
                if (alarmEvent) begin
                    state_next     = `SBIS_ST_RUN_HOLD;
                    alarmMode_next = 1'b1;
                    restart        = 1'b1;
                end else if (!servoOnCmd) begin
                    // Servo-off picks standstill or running timing from this cycle's speed.
                    alarmMode_next = 1'b0;
                    restart        = 1'b1;
                    state_next     = stopped ? `SBIS_ST_STOP_HOLD : `SBIS_ST_RUN_HOLD;
                end
            end
            `SBIS_ST_STOP_HOLD: begin
                // An alarm during a standstill hold switches to running alarm timing.
                if (alarmEvent) begin
                    state_next     = `SBIS_ST_RUN_HOLD;
                    alarmMode_next = 1'b1;
                    restart        = 1'b1;
                end else if (delayDone) begin
                    state_next = `SBIS_ST_OFF;
                end
            end
            default: begin
                // A first alarm during a running servo-off hold restarts with alarm timing.
                if (alarmEvent && !alarmMode_reg) begin
                    alarmMode_next = 1'b1;
                    restart        = 1'b1;
                end else if (delayDone || stopped || belowRelease) begin
                    state_next = `SBIS_ST_OFF;
                end
            end
        endcase

        // A servo-on edge during a hold is remembered and acted on once the hold
        // has ended at standstill, provided the host still asks for servo on.
        // Dropping the command or any alarm forgets it.
        // Reassert during hold waits
        if (inHold && onEdge && !alarm_next) begin
            pendingOn_next = 1'b1;
        end
        if (inHold && (!servoOnCmd || alarm_next)) begin
            pendingOn_next = 1'b0;
        end

    end

    // ============================================================
    // Brake delay timer
    // The timer counts milliseconds of TICK_CYCLES clocks each. It is reloaded
    // at every hold entry, so a new alarm in a servo-off hold gets the full
    // running delay rather than what was left of the servo-off delay.
    always @* begin
        tickCnt_next  = tickCnt_reg;
        delayCnt_next = delayCnt_reg;
        if (restart) begin
            tickCnt_next  = `SBIS_TICK_RESET;
            delayCnt_next = (state_next == `SBIS_ST_STOP_HOLD) ? standstillBrakeDelay : runningBrakeDelay;
        end else if (inHold && !delayDone) begin
            if (tickCnt_reg == TICK_LAST) begin
                tickCnt_next  = `SBIS_TICK_RESET;
                delayCnt_next = delayCnt_reg - 16'h0001;
            end else begin
                tickCnt_next = tickCnt_reg + 14'h0001;
            end
        end
    end

    // ============================================================
    // Registered outputs
    reg servoRelease_next;
    reg powerOn_next;
    reg releaseOut_next;
    reg [GP_WIDTH-1:0] gp_next;

    always @* begin
        // Release and power stay up through the hold-off period.
        powerOn_next      = (state_next == `SBIS_ST_ON) || isHold(state_next);
        servoRelease_next = powerOn_next;
        releaseOut_next   = servoRelease_next | networkBrakeRelease;
        // The brake bit overrides the chosen general output; the others pass through.
        // Drive onto general output
        gp_next                    = generalOutputValue;
        gp_next[brakeOutputSelect] = releaseOut_next;
    end

    // ============================================================
    // Output flip-flops
    // Every output is a flip-flop fed from the next state, so the outputs
    // change together on the edge that moves the sequencer.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg          <= `SBIS_ST_OFF;
            delayCnt_reg       <= `SBIS_DELAY_RESET;
            tickCnt_reg        <= `SBIS_TICK_RESET;
            cmdPrev_reg        <= 1'b0;
            pendingOn_reg      <= 1'b0;
            alarmMode_reg      <= 1'b0;
            motorPowerOn       <= 1'b0;
            servoOnState       <= 1'b0;
            brakeReleaseOutput <= 1'b0;
            generalOutputs     <= {GP_WIDTH{1'b0}};
            dynamicBrakeActive <= 1'b0;
            dynamicBrakeMode   <= `SBIS_SELECT_RESET;
            alarmActive        <= 1'b0;
            powerLossAlarm     <= 1'b0;
            warningCode        <= `SBIS_WARN_NONE;
            warningPulse       <= 1'b0;
        end else begin
            state_reg          <= state_next;
            delayCnt_reg       <= delayCnt_next;
            tickCnt_reg        <= tickCnt_next;
            cmdPrev_reg        <= servoOnCmd;
            pendingOn_reg      <= pendingOn_next;
            alarmMode_reg      <= alarmMode_next;
            motorPowerOn       <= powerOn_next;
            servoOnState       <= (state_next == `SBIS_ST_ON);
            brakeReleaseOutput <= releaseOut_next;
            generalOutputs     <= gp_next;
            // Dynamic brake is armed whenever the servo is not on; its mode is
            // alarmStopSelect under alarm timing or a latched alarm, otherwise servoOffStopSelect.
            dynamicBrakeActive <= (state_next != `SBIS_ST_ON);
            dynamicBrakeMode   <= alarmMode_next ? alarmStopSelect : servoOffStopSelect;
            alarmActive        <= alarm_next;
            powerLossAlarm     <= powerAlarm_next;
            warningPulse       <= warn_next;
            // The code holds its last value; only the pulse marks a new warning.
            if (warn_next) begin
                warningCode <= `SBIS_WARN_SERVO_ON;
            end
        end
    end

endmodule

`default_nettype wire

/* File: hw/sbis_regs.vh */
// Purpose: Named constants for the servo brake interlock sequencer.
// Assumes: 10 MHz control clock; delays are set in milliseconds, speeds in r/min.
// Notes:   Included by hw/sbis_sequencer.v only.
`ifndef SBIS_REGS_VH
`define SBIS_REGS_VH

// ============================================================
// Timing
`define SBIS_CLK_PERIOD_NS   100
`define SBIS_DELAY_UNIT_NS   1000000
`define SBIS_TICK_CYCLES     (`SBIS_DELAY_UNIT_NS / `SBIS_CLK_PERIOD_NS)

// ============================================================
// Speed limits and codes
`define SBIS_STOP_SPEED_RPM  16'h001E
`define SBIS_WARN_SERVO_ON   8'h95
`define SBIS_WARN_NONE       8'h00

// ============================================================
// Sequencer states
`define SBIS_ST_OFF          2'h0
`define SBIS_ST_ON           2'h1
`define SBIS_ST_STOP_HOLD    2'h2
`define SBIS_ST_RUN_HOLD     2'h3

// ============================================================
// Reset values
`define SBIS_DELAY_RESET     16'h0000
`define SBIS_TICK_RESET      14'h0000
`define SBIS_SELECT_RESET    4'h0

`endif

/* File: testbench/sbis_sva.sv */
// Purpose: Port assertions for the brake interlock sequencer.
// Assumes: brakeOutputSelect stays constant during a run.
// Notes:   Bound to the design from tb_top.
`default_nettype none
module sbis_sva (
    // Clock, reset and inputs
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        servoOnCmd,
    input wire logic        networkBrakeRelease,
    input wire logic [15:0] motorSpeed,
    input wire logic [1:0]  brakeOutputSelect,
    // Outputs
    input wire logic        motorPowerOn,
    input wire logic        servoOnState,
    input wire logic        brakeReleaseOutput,
    input wire logic [3:0]  generalOutputs,
    input wire logic        dynamicBrakeActive,
    input wire logic [7:0]  warningCode,
    input wire logic        warningPulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence onDrop; servoOnState && !servoOnCmd; endsequence
    sequence holdEntry; !servoOnState && motorPowerOn && brakeReleaseOutput; endsequence
    relOr_follow_a: assert property (networkBrakeRelease |=> brakeReleaseOutput)
        else $error("release output missed network request");
    gp_bit_a: assert property (!$past(reset) |-> generalOutputs[brakeOutputSelect] == brakeReleaseOutput)
        else $error("general output bit differs from release");
    rel_off_a: assert property (!$past(reset) && !motorPowerOn |-> brakeReleaseOutput == $past(networkBrakeRelease))
        else $error("release held while motor unpowered");
    off_hold_a: assert property (onDrop |=> holdEntry)
        else $error("servo off skipped the brake hold");
    on_slow_a: assert property ($rose(servoOnState) |-> $past(motorSpeed) <= 16'h001E)
        else $error("servo on entered while rotating");
    warn_fast_a: assert property (warningPulse |-> $past(motorSpeed) > 16'h001E && warningCode == 8'h95)
        else $error("warning without rotating servo on");
    warn_once_a: assert property (warningPulse |=> !warningPulse)
        else $error("warning pulse longer than one cycle");
    dyn_off_a: assert property (!$past(reset) |-> dynamicBrakeActive == !servoOnState)
        else $error("dynamic brake disagrees with servo state");
    power_on_a: assert property (servoOnState |-> motorPowerOn)
        else $error("servo on without motor power");
endmodule
`default_nettype wire

/* File: testbench/sbis_host_model.sv */
// Purpose: Host controller model issuing servo and brake commands.
// Assumes: Requests change just after a rising clock edge.
// Notes:   The bench decides what the host wants each cycle.
`default_nettype none
module sbis_host_model (
    input  wire logic clk,
    input  wire logic onWanted,
    input  wire logic relWanted,
    output var  logic servoOnCmd,
    output var  logic networkBrakeRelease
);
    timeunit 1ns;
    timeprecision 1ns;
    initial servoOnCmd = 1'b0;
    initial networkBrakeRelease = 1'b0;
    // Delays, cooling gaps and fresh requests come from the bench.
    always @(posedge clk) begin
        servoOnCmd <= #1 onWanted;
        networkBrakeRelease <= #1 relWanted;
    end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the brake interlock sequencer.
// Assumes: One millisecond is shortened to TICK clock cycles.
// Notes:   Expected values are worked out inline by the test sequence below.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam integer TICK = 4;
    logic clk = 1'b0, reset = 1'b1, onWanted = 1'b0, relWanted = 1'b0;
    logic alarmReset = 1'b0, alarmIn = 1'b0, mainPowerOk = 1'b1;
    logic servoOnCmd, networkBrakeRelease, powerOn, onState, brakeOut, dbAct, almAct, pwrAlm, warnPulse;
    logic [15:0] speed = 16'h0000, stillDly = 16'h0001, runDly = 16'h0002, relSpeed = 16'h0000;
    logic [3:0] offSel = 4'h3, almSel = 4'hA, gpVal = 4'h0, gpOut, dbMode;
    logic [1:0] bSel = 2'h0;
    logic [7:0] warnCode;
    integer err_total = 0, num_checks = 0, n, i, expN;
    integer dropSpd[3] = '{150, 30, 500};
    integer relSpd[3] = '{200, 0, 0};
    integer dly[3] = '{256, 256, 2};
    always #50 clk = ~clk;
    sbis_host_model sbis_host_model_i (.clk(clk), .onWanted(onWanted), .relWanted(relWanted),
        .servoOnCmd(servoOnCmd), .networkBrakeRelease(networkBrakeRelease));
    sbis_sequencer #(.TICK_CYCLES(TICK)) sbis_sequencer_i (.clk(clk), .reset(reset), .servoOnCmd(servoOnCmd),
        .networkBrakeRelease(networkBrakeRelease), .alarmReset(alarmReset), .motorSpeed(speed),
        .alarmIn(alarmIn), .mainPowerOk(mainPowerOk), .standstillBrakeDelay(stillDly),
        .runningBrakeDelay(runDly), .brakeReleaseSpeed(relSpeed), .servoOffStopSelect(offSel),
        .alarmStopSelect(almSel), .brakeOutputSelect(bSel), .generalOutputValue(gpVal),
        .motorPowerOn(powerOn), .servoOnState(onState), .brakeReleaseOutput(brakeOut),
        .generalOutputs(gpOut), .dynamicBrakeActive(dbAct), .dynamicBrakeMode(dbMode),
        .alarmActive(almAct), .powerLossAlarm(pwrAlm), .warningCode(warnCode), .warningPulse(warnPulse));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic chkCount(input string what, input integer exp, input integer got);
        num_checks++;
        if (got < exp - 2 || got > exp + 2) begin
            err_total++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cyc(input integer k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic goOn;
        speed = 16'h0000;
        onWanted = 1'b1;
        cyc(4);
        chk("servoOnState", 1, onState);
    endtask
    task automatic waitOff(output integer k);
        k = 0;
        while (powerOn === 1'b1 && k < 2000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        finish_test;
    end
    initial begin
        void'($urandom(32'hA37AACAF));
        bSel = 2'($urandom());
        cyc(2);
        reset = 1'b0;
        for (i = 0; i < 4; i++) begin
            gpVal = 4'($urandom());
            relWanted = 1'($urandom());
            cyc(3);
            chk("brakeReleaseOutput", 16'(relWanted), brakeOut);
            chk("generalOutputs", 16'((gpVal & ~(4'h1 << bSel)) | (4'(relWanted) << bSel)), gpOut);
        end
        relWanted = 1'b0;
        speed = 16'h0064;
        onWanted = 1'b1;
        cyc(4);
        chk("servoOnState", 0, onState);
        chk("warningCode", 16'h0095, warnCode);
        onWanted = 1'b0;
        cyc(2);
        for (i = 1; i < 3; i++) begin
            goOn();
            stillDly = 16'(i);
            onWanted = 1'b0;
            cyc(2);
            chk("dynamicBrakeMode", offSel, dbMode);
            chk("brakeReleaseOutput", 1, brakeOut);
            waitOff(n);
            chkCount("standstill hold", i * TICK + 1, n);
            chk("brakeReleaseOutput", 0, brakeOut);
        end
        for (i = 0; i < 3; i++) begin
            goOn();
            speed = 16'h01F4;
            runDly = 16'(dly[i]);
            relSpeed = 16'(relSpd[i]);
            onWanted = 1'b0;
            cyc(2);
            speed = 16'(dropSpd[i]);
            expN = (dropSpd[i] <= 30 || dropSpd[i] <= relSpd[i]) ? 1 : dly[i] * TICK + 1;
            waitOff(n);
            chkCount("running hold", expN, n);
        end
        // A servo-on edge during a running hold waits for standstill.
        goOn();
        speed = 16'h01F4;
        onWanted = 1'b0;
        cyc(2);
        onWanted = 1'b1;
        cyc(2);
        chk("servoOnState", 0, onState);
        speed = 16'h0000;
        cyc(4);
        chk("servoOnState", 1, onState);
        goOn();
        speed = 16'h01F4;
        mainPowerOk = 1'b0;
        cyc(5);
        chk("powerLossAlarm", 1, pwrAlm);
        chk("dynamicBrakeMode", almSel, dbMode);
        waitOff(n);
        chkCount("alarm hold", 2 * TICK, n);
        mainPowerOk = 1'b1;
        speed = 16'h0000;
        alarmReset = 1'b1;
        cyc(1);
        alarmReset = 1'b0;
        cyc(4);
        chk("powerLossAlarm", 0, pwrAlm);
        chk("servoOnState", 0, onState);
        onWanted = 1'b0;
        cyc(3);
        goOn();
        speed = 16'h01F4;
        alarmIn = 1'b1;
        cyc(1);
        alarmIn = 1'b0;
        cyc(3);
        chk("alarmActive", 1, almAct);
        chk("dynamicBrakeMode", almSel, dbMode);
        waitOff(n);
        chk("servoOnState", 0, onState);
        finish_test;
    end
endmodule
bind sbis_sequencer sbis_sva sbis_sva_i (.clk(clk), .reset(reset), .servoOnCmd(servoOnCmd),
    .networkBrakeRelease(networkBrakeRelease), .motorSpeed(motorSpeed), .brakeOutputSelect(brakeOutputSelect),
    .motorPowerOn(motorPowerOn), .servoOnState(servoOnState), .brakeReleaseOutput(brakeReleaseOutput),
    .generalOutputs(generalOutputs), .dynamicBrakeActive(dynamicBrakeActive), .warningCode(warningCode),
    .warningPulse(warningPulse));
`default_nettype wire
